// ---- rtl/fscd_pkg.sv ----
// Purpose: Constants and carrier types for the filter/shutter command decoder
// Assumes: Byte link delivers one byte per valid/ready handshake
// Notes:   All codes and counts live here; design uses fscd_pkg::name
package fscd_pkg;
	localparam logic [7:0] CMD_WHEEL_C_PFX  = 8'hfc;
	localparam logic [7:0] CMD_SHA_OPEN     = 8'haa;
	localparam logic [7:0] CMD_SHA_COND     = 8'hab;
	localparam logic [7:0] CMD_SHA_CLOSE    = 8'hac;
	localparam logic [7:0] CMD_SHB_OPEN     = 8'hba;
	localparam logic [7:0] CMD_SHB_COND     = 8'hbb;
	localparam logic [7:0] CMD_SHB_CLOSE    = 8'hbc;
	localparam logic [7:0] CMD_GROUP_BEGIN  = 8'hbd;
	localparam logic [7:0] CMD_GROUP_END    = 8'hbe;
	localparam logic [7:0] BYTE_CR          = 8'h0d;
	localparam int         GROUP_DEPTH      = 6;
	localparam int         WHEEL_SEL_BIT    = 7;
	localparam int         SPEED_MSB        = 6;
	localparam int         SPEED_LSB        = 4;
	localparam int         POS_MSB          = 3;
	localparam int         POS_LSB          = 0;
	localparam logic [2:0] RST_GROUP_COUNT  = 3'h0;

	typedef enum logic [1:0] {
		FSCD_WHEEL_A = 2'h0,
		FSCD_WHEEL_B = 2'h1,
		FSCD_WHEEL_C = 2'h2
	} fscd_wheel_e;

	typedef enum logic [1:0] {
		FSCD_SH_CLOSED = 2'h0,
		FSCD_SH_OPEN   = 2'h1,
		FSCD_SH_COND   = 2'h2
	} fscd_shmode_e;

	// One wheel move request
	typedef struct packed {
		fscd_wheel_e wheel;
		logic [2:0]  speed;
		logic [3:0]  position;
	} fscd_move_s;

	// Buffered group entry: raw byte plus wheel C prefix flag
	typedef struct packed {
		logic       pfx_c;
		logic [7:0] code;
	} fscd_entry_s;
endpackage

// ---- rtl/fscd_decoder.sv ----
// Purpose: Decode host command bytes into wheel moves and shutter actions
// Assumes: Single clock; wheel motion reported by wheel_busy_in
// Notes:   Echo and CR share one transmit handshake, echo has priority
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - Bit 7 of a wheel byte picks wheel A (or C after prefix) at 0, B at 1.
// R2 - A 0xfc prefix before a wheel byte with bit 7 clear targets wheel C.
// R3 - Wheel speed 0..7 is taken from bits 6 to 4 of the wheel byte.
// R4 - Filter position 0..9 is the BCD low nibble of the wheel byte.
// R5 - Byte 0xaa opens shutter A.
// R6 - Byte 0xab puts shutter A in conditional-open mode.
// R7 - A conditional shutter closes while a wheel moves and reopens after.
// R8 - Byte 0xac closes shutter A.
// R9 - Byte 0xba opens shutter B.
// R10 - Byte 0xbb puts shutter B in conditional-open mode.
// R11 - Byte 0xbc closes shutter B.
// R12 - After 0xbd, up to six wheel and shutter bytes are stored, not run.
// R13 - Byte 0xbe runs the stored group actions back to back.
// R14 - A group accepts wheel A, B, C (with prefix) and shutter A, B actions.
// R15 - Every received byte is echoed back to the host.
// R16 - A carriage return is sent once a command's action has finished.
// R17 - After reset the decoder is idle, no prefix, empty group.
module fscd_decoder (
	input  wire logic              clock_in,
	input  wire logic              rst_b_in,
	input  wire logic              clk_en_in,
	input  wire logic              rx_valid_in,
	input  wire logic [7:0]        rx_data_in,
	output logic                   rx_ready_out,
	output logic                   tx_valid_out,
	output logic [7:0]             tx_data_out,
	input  wire logic              tx_ready_in,
	output logic                   move_valid_out,
	output fscd_pkg::fscd_move_s   move_out,
	input  wire logic              move_ready_in,
	input  wire logic              wheel_busy_in,
	output logic                   shutter_a_open_out,
	output logic                   shutter_b_open_out
);

	typedef enum logic [3:0] {
		FSCD_IDLE  = 4'b0001,
		FSCD_ECHO  = 4'b0010,
		FSCD_EXEC  = 4'b0100,
		FSCD_DONE  = 4'b1000
	} fscd_state_e;

	fscd_state_e            state_r, state_nxt;
	logic [7:0]             byte_r, byte_nxt;
	logic                   pfx_r, pfx_nxt;
	logic                   cur_pfx_r, cur_pfx_nxt;
	logic                   grp_on_r, grp_on_nxt;
	logic                   grp_run_r, grp_run_nxt;
	logic [2:0]             grp_cnt_r, grp_cnt_nxt;
	logic [2:0]             grp_idx_r, grp_idx_nxt;
	fscd_pkg::fscd_entry_s  grp_mem_r [fscd_pkg::GROUP_DEPTH];
	fscd_pkg::fscd_entry_s  grp_wr;
	logic                   grp_we;
	fscd_pkg::fscd_shmode_e sha_r, sha_nxt, shb_r, shb_nxt;
	logic                   mv_r, mv_nxt;
	fscd_pkg::fscd_move_s   mv_d_r, mv_d_nxt;
	logic                   cr_r, cr_nxt;
	logic [7:0]             tx_d_r, tx_d_nxt;
	logic                   exec_pfx;
	logic [7:0]             exec_code;
	logic                   is_wheel, is_shut;

	////////////////////////////////////////////////////////////////////////
	// Action executed by the EXEC state: current byte or group entry
	always_comb begin
		if (grp_run_r) begin
			exec_code = grp_mem_r[grp_idx_r].code;
			exec_pfx  = grp_mem_r[grp_idx_r].pfx_c;
		end else begin
			exec_code = byte_r;
			exec_pfx  = cur_pfx_r;
		end
	end

	// Wheel bytes: any byte whose low nibble is 0..9, whatever bit 7 holds
	assign is_shut = (byte_r == fscd_pkg::CMD_SHA_OPEN) ||
		(byte_r == fscd_pkg::CMD_SHA_COND) ||
		(byte_r == fscd_pkg::CMD_SHA_CLOSE) ||
		(byte_r == fscd_pkg::CMD_SHB_OPEN) ||
		(byte_r == fscd_pkg::CMD_SHB_COND) ||
		(byte_r == fscd_pkg::CMD_SHB_CLOSE);
	assign is_wheel = (byte_r[fscd_pkg::POS_MSB:fscd_pkg::POS_LSB] <= 4'h9);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt     = state_r;
		byte_nxt      = byte_r;
		pfx_nxt       = pfx_r;
		cur_pfx_nxt   = cur_pfx_r;
		grp_on_nxt    = grp_on_r;
		grp_run_nxt   = grp_run_r;
		grp_cnt_nxt   = grp_cnt_r;
		grp_idx_nxt   = grp_idx_r;
		sha_nxt       = sha_r;
		shb_nxt       = shb_r;
		mv_nxt        = mv_r;
		mv_d_nxt      = mv_d_r;
		cr_nxt        = cr_r;
		tx_d_nxt      = tx_d_r;
		grp_we        = 1'b0;
		grp_wr        = '{pfx_c: pfx_r, code: byte_r};
		case (state_r)
			FSCD_IDLE: begin
				if (rx_valid_in) begin
					byte_nxt  = rx_data_in;
					tx_d_nxt  = rx_data_in; // R15
					state_nxt = FSCD_ECHO;
				end
			end
			FSCD_ECHO: begin
				if (tx_ready_in) begin
					state_nxt = FSCD_IDLE;
					if (byte_r == fscd_pkg::CMD_WHEEL_C_PFX) begin
						pfx_nxt = 1'b1; // R2
					end else if (byte_r == fscd_pkg::CMD_GROUP_BEGIN) begin
						grp_on_nxt  = 1'b1; // R12
						grp_cnt_nxt = fscd_pkg::RST_GROUP_COUNT;
						pfx_nxt     = 1'b0;
					end else if (byte_r == fscd_pkg::CMD_GROUP_END &&
						grp_on_r) begin
						grp_on_nxt  = 1'b0;
						grp_run_nxt = (grp_cnt_r != 3'h0); // R13
						grp_idx_nxt = 3'h0;
						state_nxt   = (grp_cnt_r != 3'h0) ? FSCD_EXEC : FSCD_DONE;
					end else if (grp_on_r) begin
						// Excess entries beyond six are dropped
						if ((is_shut || is_wheel) &&
							grp_cnt_r < 3'(fscd_pkg::GROUP_DEPTH)) begin
							grp_we      = 1'b1; // R14
							grp_cnt_nxt = grp_cnt_r + 3'h1;
						end
						pfx_nxt = 1'b0;
					end else if (is_shut || is_wheel) begin
						cur_pfx_nxt = pfx_r;
						pfx_nxt     = 1'b0;
						state_nxt   = FSCD_EXEC;
					end else begin
						pfx_nxt   = 1'b0;
						state_nxt = FSCD_DONE;
					end
				end
			end
			FSCD_EXEC: begin
				if (!mv_r) begin
					case (exec_code)
						fscd_pkg::CMD_SHA_OPEN:  sha_nxt = fscd_pkg::FSCD_SH_OPEN; // R5
						fscd_pkg::CMD_SHA_COND:  sha_nxt = fscd_pkg::FSCD_SH_COND; // R6
						fscd_pkg::CMD_SHA_CLOSE: sha_nxt = fscd_pkg::FSCD_SH_CLOSED; // R8
						fscd_pkg::CMD_SHB_OPEN:  sha_nxt = sha_r;
						default: ;
					endcase
					case (exec_code)
						fscd_pkg::CMD_SHB_OPEN:  shb_nxt = fscd_pkg::FSCD_SH_OPEN; // R9
						fscd_pkg::CMD_SHB_COND:  shb_nxt = fscd_pkg::FSCD_SH_COND; // R10
						fscd_pkg::CMD_SHB_CLOSE: shb_nxt = fscd_pkg::FSCD_SH_CLOSED; // R11
						default: ;
					endcase
					if (exec_code[fscd_pkg::POS_MSB:fscd_pkg::POS_LSB] <= 4'h9 &&
						!(exec_code inside {fscd_pkg::CMD_SHA_OPEN,
						fscd_pkg::CMD_SHA_COND, fscd_pkg::CMD_SHA_CLOSE,
						fscd_pkg::CMD_SHB_OPEN, fscd_pkg::CMD_SHB_COND,
						fscd_pkg::CMD_SHB_CLOSE})) begin
						mv_nxt = 1'b1;
						if (exec_code[fscd_pkg::WHEEL_SEL_BIT]) begin
							mv_d_nxt.wheel = fscd_pkg::FSCD_WHEEL_B; // R1
						end else if (exec_pfx) begin
							mv_d_nxt.wheel = fscd_pkg::FSCD_WHEEL_C; // R2
						end else begin
							mv_d_nxt.wheel = fscd_pkg::FSCD_WHEEL_A; // R1
						end
						mv_d_nxt.speed = exec_code[fscd_pkg::SPEED_MSB:
							fscd_pkg::SPEED_LSB]; // R3
						mv_d_nxt.position = exec_code[fscd_pkg::POS_MSB:
							fscd_pkg::POS_LSB]; // R4
					end else if (grp_run_r &&
						grp_idx_r + 3'h1 < grp_cnt_r) begin
						grp_idx_nxt = grp_idx_r + 3'h1; // R13
					end else begin
						grp_run_nxt = 1'b0;
						state_nxt   = FSCD_DONE;
					end
				end else if (move_ready_in) begin
					mv_nxt = 1'b0;
					if (grp_run_r && grp_idx_r + 3'h1 < grp_cnt_r) begin
						grp_idx_nxt = grp_idx_r + 3'h1;
					end else begin
						grp_run_nxt = 1'b0;
						state_nxt   = FSCD_DONE;
					end
				end
			end
			FSCD_DONE: begin
				// Wait for the wheel to stop before reporting completion
				if (!wheel_busy_in) begin
					cr_nxt   = 1'b1; // R16
					tx_d_nxt = fscd_pkg::BYTE_CR;
				end
				if (cr_r && tx_ready_in) begin
					cr_nxt    = 1'b0;
					state_nxt = FSCD_IDLE;
				end
			end
			default: state_nxt = FSCD_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r     <= FSCD_IDLE; // R17
			byte_r      <= 8'h00;
			pfx_r       <= 1'b0;
			cur_pfx_r   <= 1'b0;
			grp_on_r    <= 1'b0;
			grp_run_r   <= 1'b0;
			grp_cnt_r   <= fscd_pkg::RST_GROUP_COUNT;
			grp_idx_r   <= 3'h0;
			sha_r       <= fscd_pkg::FSCD_SH_CLOSED;
			shb_r       <= fscd_pkg::FSCD_SH_CLOSED;
			mv_r        <= 1'b0;
			mv_d_r      <= '0;
			cr_r        <= 1'b0;
			tx_d_r      <= 8'h00;
		end else if (clk_en_in) begin
			state_r     <= state_nxt;
			byte_r      <= byte_nxt;
			pfx_r       <= pfx_nxt;
			cur_pfx_r   <= cur_pfx_nxt;
			grp_on_r    <= grp_on_nxt;
			grp_run_r   <= grp_run_nxt;
			grp_cnt_r   <= grp_cnt_nxt;
			grp_idx_r   <= grp_idx_nxt;
			sha_r       <= sha_nxt;
			shb_r       <= shb_nxt;
			mv_r        <= mv_nxt;
			mv_d_r      <= mv_d_nxt;
			cr_r        <= cr_nxt;
			tx_d_r      <= tx_d_nxt;
		end
	end

	// Group store has no reset; entries are only read below grp_cnt_r
	always_ff @(posedge clock_in) begin
		if (clk_en_in && grp_we) begin
			grp_mem_r[grp_cnt_r] <= grp_wr; // R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign rx_ready_out   = (state_r == FSCD_IDLE);
	assign tx_valid_out   = (state_r == FSCD_ECHO) ||
		(state_r == FSCD_DONE && cr_r);
	assign tx_data_out    = tx_d_r;
	assign move_valid_out = mv_r;
	assign move_out       = mv_d_r;
	// Conditional shutters follow the wheel's motion
	assign shutter_a_open_out = (sha_r == fscd_pkg::FSCD_SH_OPEN) ||
		(sha_r == fscd_pkg::FSCD_SH_COND && !wheel_busy_in); // R7
	assign shutter_b_open_out = (shb_r == fscd_pkg::FSCD_SH_OPEN) ||
		(shb_r == fscd_pkg::FSCD_SH_COND && !wheel_busy_in); // R7

endmodule

// ---- tb/fscd_assertions.sv ----
// Purpose: Port checks for fscd_decoder
// Assumes: One clock, rst_b_in async low
// Notes:   Shutter checks skip bytes inside a group
`timescale 1ns/10ps
module fscd_assertions (
	input wire logic                 clock_in,
	input wire logic                 rst_b_in,
	input wire logic                 clk_en_in,
	input wire logic                 rx_valid_in,
	input wire logic [7:0]           rx_data_in,
	input wire logic                 rx_ready_out,
	input wire logic                 tx_valid_out,
	input wire logic [7:0]           tx_data_out,
	input wire logic                 tx_ready_in,
	input wire logic                 move_valid_out,
	input wire fscd_pkg::fscd_move_s move_out,
	input wire logic                 move_ready_in,
	input wire logic                 shutter_a_open_out,
	input wire logic                 shutter_b_open_out
);
	logic tk;
	logic grp_r;
	logic grp_nxt;
	assign tk = rx_valid_in & rx_ready_out & clk_en_in;
	// Track group bracket from the wire, grouped bytes run late
	always_comb begin
		grp_nxt = grp_r;
		if (tk && rx_data_in == fscd_pkg::CMD_GROUP_BEGIN) grp_nxt = 1'b1;
		if (tk && rx_data_in == fscd_pkg::CMD_GROUP_END) grp_nxt = 1'b0;
	end
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) grp_r <= 1'b0;
		else grp_r <= grp_nxt;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	property p_echo;
		tk |=> tx_valid_out && tx_data_out == $past(rx_data_in);
	endproperty
	a_echo: assert property (p_echo)
		else $error("echo missing");
	property p_refuse;
		tx_valid_out |-> !rx_ready_out;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("byte taken early");
	property p_txhold;
		tx_valid_out && !tx_ready_in |=>
			tx_valid_out && $stable(tx_data_out);
	endproperty
	a_txhold: assert property (p_txhold)
		else $error("tx byte lost");
	property p_mvhold;
		move_valid_out && !move_ready_in |=>
			move_valid_out && $stable(move_out);
	endproperty
	a_mvhold: assert property (p_mvhold)
		else $error("move dropped");
	property p_sha_open;
		tk && !grp_r && rx_data_in == fscd_pkg::CMD_SHA_OPEN |->
			##[1:40] shutter_a_open_out;
	endproperty
	a_sha_open: assert property (p_sha_open)
		else $error("A not opened");
	property p_sha_close;
		tk && !grp_r && rx_data_in == fscd_pkg::CMD_SHA_CLOSE |->
			##[1:40] !shutter_a_open_out;
	endproperty
	a_sha_close: assert property (p_sha_close)
		else $error("A not closed");
	property p_shb_open;
		tk && !grp_r && rx_data_in == fscd_pkg::CMD_SHB_OPEN |->
			##[1:40] shutter_b_open_out;
	endproperty
	a_shb_open: assert property (p_shb_open)
		else $error("B not opened");
	property p_rst;
		$rose(rst_b_in) |->
			rx_ready_out && !tx_valid_out && !move_valid_out;
	endproperty
	a_rst: assert property (p_rst)
		else $error("not idle after reset");
endmodule

// ---- tb/fscd_host_model.sv ----
// Purpose: Host end of the byte link
// Assumes: Device echoes every byte it takes
// Notes:   Ready stalls at random to stretch echo and CR
`timescale 1ns/10ps
module fscd_host_model (
	input  wire logic       clock_in,
	input  wire logic       rx_ready_in,
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	output logic            rx_valid_out,
	output logic [7:0]      rx_data_out,
	output logic            tx_ready_out
);
	integer     seed = 88116;
	logic [7:0] q[$];
	initial begin
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
		tx_ready_out = 1'b0;
	end
	always @(posedge clock_in) begin
		if (tx_valid_in && tx_ready_out) q.push_back(tx_data_in);
		tx_ready_out <= ($random(seed) & 3) != 0;
	end
	// Byte held until taken, then inverted so stale data never matches
	task automatic send(input logic [7:0] b);
		@(posedge clock_in);
		rx_valid_out <= 1'b1;
		rx_data_out <= b;
		do @(negedge clock_in); while (!rx_ready_in);
		@(posedge clock_in);
		rx_valid_out <= 1'b0;
		rx_data_out <= ~b;
	endtask
endmodule

// ---- tb/filter_shutter_cmd_decoder_test.sv ----
// Purpose: Self-checking bench for fscd_decoder
// Assumes: Host model and a small motor model face the block
// Notes:   clk_en held high; freezing is not exercised
`timescale 1ns/10ps
module filter_shutter_cmd_decoder_test;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic clk_en_in = 1'b1;
	logic mv_rdy = 1'b0;
	logic busy = 1'b0;
	logic rxv, rxr, txv, txr, mvv, sha, shb;
	logic [7:0] rxd, txd, b;
	fscd_pkg::fscd_move_s mv;
	logic [8:0] mq[$];
	logic [7:0] sc[4] = '{8'haa, 8'hac, 8'hba, 8'hbc};
	logic [1:0] se[4] = '{2'h2, 2'h0, 2'h1, 2'h0};
	logic [7:0] cw[3] = '{8'h00, 8'hf9, 8'h79};
	integer seed = 88116;
	integer miscompares = 0;
	integer total_checks = 0;
	integer cycles = 0;
	integer busy_n = 0;
	bit cond_a = 0;
	bit cond_b = 0;
	bit pfx;
	always #25 clock_in = ~clock_in;
	fscd_decoder fscd_decoder_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.clk_en_in(clk_en_in), .rx_valid_in(rxv), .rx_data_in(rxd),
		.rx_ready_out(rxr), .tx_valid_out(txv), .tx_data_out(txd),
		.tx_ready_in(txr), .move_valid_out(mvv), .move_out(mv),
		.move_ready_in(mv_rdy), .wheel_busy_in(busy),
		.shutter_a_open_out(sha), .shutter_b_open_out(shb));
	fscd_host_model fscd_host_model_inst (.clock_in(clock_in),
		.rx_ready_in(rxr), .tx_valid_in(txv), .tx_data_in(txd),
		.rx_valid_out(rxv), .rx_data_out(rxd), .tx_ready_out(txr));
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		total_checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [8:0] exp_move(input logic [7:0] v, input bit c);
		return {c ? 2'h2 : {1'b0, v[7]}, v[6:4], v[3:0]};
	endfunction
	// Ceiling well above the several hundred cycles the tests take
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// Motor stand-in: random accept, busy for four cycles per move
	always @(posedge clock_in) begin
		mv_rdy <= 1'($random(seed) & 1);
		if (mvv && mv_rdy) begin
			mq.push_back(mv);
			busy_n = 4;
		end
		busy <= busy_n != 0;
		if (busy_n != 0) busy_n--;
	end
	always @(negedge clock_in) begin
		if (cond_a && busy) chk("sha_busy", 9'h000, {8'h00, sha});
		if (cond_b && busy) chk("shb_busy", 9'h000, {8'h00, shb});
	end
	task automatic exec(input logic [7:0] v, input bit cr);
		integer     n;
		logic [8:0] got;
		n = 0;
		fscd_host_model_inst.send(v);
		while (fscd_host_model_inst.q.size() < 1 + cr && n < 400) begin
			@(posedge clock_in);
			n++;
		end
		repeat (6) @(posedge clock_in);
		got = {1'b0, fscd_host_model_inst.q[0]};
		chk("echo", {1'b0, v}, got);
		if (cr) begin
			got = {1'b0, fscd_host_model_inst.q[1]};
			chk("cr", {1'b0, fscd_pkg::BYTE_CR}, got);
		end
		got = 9'(fscd_host_model_inst.q.size());
		chk("tx_count", 9'(1 + cr), got);
		fscd_host_model_inst.q.delete();
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clock_in);
		rst_b_in <= 1'b1;
		@(negedge clock_in);
		chk("rx_ready", 9'h001, {8'h00, rxr});
		chk("shutters", 9'h000, {7'h00, sha, shb});
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			exec(sc[i], 1);
			chk("shutter", {7'h00, se[i]}, {7'h00, sha, shb});
		end
		$display("test shutter done");
		exec(fscd_pkg::CMD_SHA_COND, 1);
		exec(fscd_pkg::CMD_SHB_COND, 1);
		chk("cond_idle", 9'h003, {7'h00, sha, shb});
		cond_a = 1;
		cond_b = 1;
		exec(8'h35, 1);
		chk("cond_move", exp_move(8'h35, 0), mq.pop_front());
		chk("cond_after", 9'h003, {7'h00, sha, shb});
		cond_a = 0;
		cond_b = 0;
		exec(fscd_pkg::CMD_SHA_CLOSE, 1);
		exec(fscd_pkg::CMD_SHB_CLOSE, 1);
		$display("test conditional done");
		for (int i = 0; i < 15; i++) begin
			b = (i < 3) ? cw[i] : 8'($random(seed));
			if (i >= 3) b[3:0] = 4'($unsigned($random(seed)) % 10);
			pfx = (i == 2) || (i > 2 && ($random(seed) & 1));
			if (pfx) b[7] = 1'b0;
			if (pfx) exec(fscd_pkg::CMD_WHEEL_C_PFX, 0);
			exec(b, 1);
			chk("move", exp_move(b, pfx), mq.pop_front());
		end
		$display("test wheel done");
		exec(fscd_pkg::CMD_GROUP_BEGIN, 0);
		exec(fscd_pkg::CMD_WHEEL_C_PFX, 0);
		exec(8'h23, 0);
		exec(8'hd7, 0);
		exec(fscd_pkg::CMD_SHA_OPEN, 0);
		chk("grp_hold", 9'h000, {8'(mq.size()), sha});
		exec(fscd_pkg::CMD_GROUP_END, 1);
		chk("grp_c", exp_move(8'h23, 1), mq.pop_front());
		chk("grp_b", exp_move(8'hd7, 0), mq.pop_front());
		chk("grp_sha", 9'h001, {8'h00, sha});
		$display("test group done");
		report_and_stop();
	end
endmodule
bind fscd_decoder fscd_assertions fscd_assertions_inst (.clock_in(clock_in),
	.rst_b_in(rst_b_in), .clk_en_in(clk_en_in), .rx_valid_in(rx_valid_in),
	.rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out),
	.tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
	.tx_ready_in(tx_ready_in), .move_valid_out(move_valid_out),
	.move_out(move_out), .move_ready_in(move_ready_in),
	.shutter_a_open_out(shutter_a_open_out),
	.shutter_b_open_out(shutter_b_open_out));
